/* File: design/drt_defs.vh */
// What this block does
// R01 - each timer has readable writable 8-bit reload
// R02 - timer a overflow pulse sets request zero
// R03 - timer b overflow pulse sets request one
// R04 - overflow loads reload value, never wraps to zero
// R05 - counter steps up one per timer tick
// R06 - overflow pulse in period after count ff
// R07 - timer a count write presets from reload
// R08 - timer b count write presets from reload
// R09 - count register reads return present count
// R10 - software programs reload as negated period
// R11 - timer a: osc1, wake gated, power-down gated, /16
// R12 - timer b: osc2 divided by 128
// R13 - reset clears reloads and counters
// R14 - power-down flag cleared by reset, reserved functions
// R15 - select bit routes timer b overflow to reserved
// R16 - ticks single-cycle; each overflow sets request once
// R17 - preset with overflow: same reload, pulse kept
`ifndef DRT_DEFS_VH
`define DRT_DEFS_VH

// register indices; byte address is four times the index
`define DRT_IDX_CLOCK_CONTROL  8'he8
`define DRT_IDX_TA_RELOAD      8'heb
`define DRT_IDX_TA_COUNT       8'hec
`define DRT_IDX_TB_RELOAD      8'hed
`define DRT_IDX_TB_COUNT       8'hee
`define DRT_IDX_IRQ_MASK       8'hfd
`define DRT_IDX_IRQ_STATUS     8'hfe

// clock_control fields
`define DRT_CC_POWER_DOWN      7
`define DRT_CC_TB_RES_SEL      6

// status and mask fields
`define DRT_IRQ_TA             0
`define DRT_IRQ_TB             1
`define DRT_IRQ_RES            2
`define DRT_IRQ_W              3

// reset values
`define DRT_RST_BYTE           8'h00
`define DRT_RST_IRQ            3'h0

// timing counts
`define DRT_TA_DIV             16
`define DRT_TB_DIV             128
`define DRT_COUNT_MAX          8'hff

`endif

/* File: design/drt_divider.v */
`timescale 1ns/10ps
// synchronises an oscillator pin and divides its rising edges
module drt_divider #(
  parameter DIV = 16
) (
  input  wire clock,
  input  wire rst,
  input  wire osc_pin,
  input  wire gate,
  output reg  tick_q
);
  reg        meta_q;
  reg        sync_q;
  reg        prev_q;
  reg  [7:0] cnt_q;
  wire       rise;

  assign rise = sync_q & ~prev_q;

  always @(posedge clock) begin
    meta_q <= osc_pin;
    sync_q <= meta_q;
    // tracks the pin through reset, so a high pin gives no false edge
    prev_q <= sync_q;
    if (rst) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (rise && gate) begin
        if (cnt_q == DIV[7:0] - 8'h01) begin
          cnt_q  <= 8'h00;
          tick_q <= 1'b1; // see R16
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule

/* File: design/drt_timer.v */
`timescale 1ns/10ps
// one 8-bit up counter with automatic reload
module drt_timer #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         rst,
  input  wire         tick,
  input  wire         preset,
  input  wire [W-1:0] reload,
  output reg  [W-1:0] count_q,
  output reg          ovf_q
);
  wire wrap;

  assign wrap = tick && (count_q == {W{1'b1}});

  always @(posedge clock) begin
    if (rst) begin
      count_q <= {W{1'b0}}; // see R13
      ovf_q   <= 1'b0;
    end else begin
      ovf_q <= wrap; // see R06 see R17
      // a preset and a wrap both take the reload value
      if (wrap || preset) begin
        count_q <= reload; // see R04 see R17
      end else if (tick) begin
        count_q <= count_q + {{(W-1){1'b0}}, 1'b1}; // see R05
      end
    end
  end
endmodule

/* File: design/drt_top.v */
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "drt_defs.vh"
// two reload timers behind an avalon-mm slave
module drt_top #(
  parameter TA_DIV = `DRT_TA_DIV,
  parameter TB_DIV = `DRT_TB_DIV
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        osc1_pin,
  input  wire        osc2_pin,
  input  wire        wake_delay_done,
  input  wire        reserved_done,
  output reg         reserved_trigger_q,
  output reg         ta_overflow_q,
  output reg         tb_overflow_q,
  output reg         irq_q
);
  // bus state
  wire       req;
  wire       acc;
  wire       rd_acc;
  wire       wr_acc;
  wire [7:0] idx;
  wire [7:0] wbyte;
  wire       wr_cc;
  wire       wr_ta_reload;
  wire       wr_tb_reload;
  wire       wr_mask;
  wire       rd_status;

  // registers
  reg  [7:0] ta_reload_q;
  reg  [7:0] tb_reload_q;
  reg  [7:0] clock_control_q;
  reg  [7:0] clock_control_d;
  reg  [`DRT_IRQ_W-1:0] status_q;
  reg  [`DRT_IRQ_W-1:0] status_d;
  reg  [`DRT_IRQ_W-1:0] mask_q;
  reg  [`DRT_IRQ_W-1:0] mask_d;
  reg  [7:0] rdata_d;

  // timer plumbing
  wire       ta_tick;
  wire       tb_tick;
  wire       ta_gate;
  wire       ta_preset;
  wire       tb_preset;
  wire [7:0] ta_count;
  wire [7:0] tb_count;
  wire       ta_ovf;
  wire       tb_ovf;
  wire       res_event;
  reg        wake_meta_q;
  reg        wake_sync_q;
  reg        rdone_meta_q;
  reg        rdone_sync_q;

  // one wait cycle: request seen with waitrequest high,
  // answered at the next edge with waitrequest low
  assign req    = avs_read | avs_write;
  assign acc    = req & ~avs_waitrequest;
  assign rd_acc = avs_read & ~avs_waitrequest;
  assign wr_acc = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign idx    = avs_address[9:2];
  assign wbyte  = avs_writedata[7:0];

  // one strobe per register, each taken at the accept edge only
  assign wr_cc        = wr_acc && (idx == `DRT_IDX_CLOCK_CONTROL);
  assign wr_ta_reload = wr_acc && (idx == `DRT_IDX_TA_RELOAD);
  assign wr_tb_reload = wr_acc && (idx == `DRT_IDX_TB_RELOAD);
  assign wr_mask      = wr_acc && (idx == `DRT_IDX_IRQ_MASK);
  assign rd_status    = rd_acc && (idx == `DRT_IDX_IRQ_STATUS);

  always @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // wake-up delay and reserved-function done arrive from
  // other clock regions, so both are synchronised first
  always @(posedge clock) begin
    wake_meta_q  <= wake_delay_done;
    wake_sync_q  <= wake_meta_q;
    rdone_meta_q <= reserved_done;
    rdone_sync_q <= rdone_meta_q;
  end

  // timer a clock runs only after wake-up and out of power-down
  assign ta_gate = wake_sync_q & ~clock_control_q[`DRT_CC_POWER_DOWN]; // see R11

  // the written data is thrown away; only the strobe matters
  assign ta_preset = wr_acc && (idx == `DRT_IDX_TA_COUNT); // see R07
  assign tb_preset = wr_acc && (idx == `DRT_IDX_TB_COUNT); // see R08

  drt_divider #(
    .DIV(TA_DIV)
  ) u_div_a (
    .clock   (clock),
    .rst     (rst),
    .osc_pin (osc1_pin),
    .gate    (ta_gate),
    .tick_q  (ta_tick)
  ); // see R11

  drt_divider #(
    .DIV(TB_DIV)
  ) u_div_b (
    .clock   (clock),
    .rst     (rst),
    .osc_pin (osc2_pin),
    .gate    (1'b1),
    .tick_q  (tb_tick)
  ); // see R12

  drt_timer #(
    .W(8)
  ) u_timer_a (
    .clock   (clock),
    .rst     (rst),
    .tick    (ta_tick),
    .preset  (ta_preset),
    .reload  (ta_reload_q),
    .count_q (ta_count),
    .ovf_q   (ta_ovf)
  );

  drt_timer #(
    .W(8)
  ) u_timer_b (
    .clock   (clock),
    .rst     (rst),
    .tick    (tb_tick),
    .preset  (tb_preset),
    .reload  (tb_reload_q),
    .count_q (tb_count),
    .ovf_q   (tb_ovf)
  );

  // timer b overflow reaches the reserved function only when selected
  assign res_event = tb_ovf & clock_control_q[`DRT_CC_TB_RES_SEL]; // see R15

  // reload registers
  always @(posedge clock) begin
    if (rst) begin
      ta_reload_q <= `DRT_RST_BYTE; // see R13
      tb_reload_q <= `DRT_RST_BYTE; // see R13
    end else begin
      if (wr_ta_reload) begin
        ta_reload_q <= wbyte; // see R01 see R10
      end
      if (wr_tb_reload) begin
        tb_reload_q <= wbyte; // see R01 see R10
      end
    end
  end

  // clock control: software write, then power-down cleared by
  // the reserved function finishing; hardware clear wins
  always @* begin
    clock_control_d = clock_control_q;
    if (wr_cc) begin
      clock_control_d = wbyte;
    end
    if (rdone_sync_q) begin
      clock_control_d[`DRT_CC_POWER_DOWN] = 1'b0; // see R14
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      clock_control_q <= `DRT_RST_BYTE; // see R14
    end else begin
      clock_control_q <= clock_control_d;
    end
  end

  // next mask, so the line follows a mask write at once
  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = wbyte[`DRT_IRQ_W-1:0];
    end
  end

  // interrupt status: read clears, a new event in the same
  // cycle still sets the bit
  always @* begin
    status_d = status_q;
    // clear only what the read reported, so an event landing
    // between data capture and acceptance is not lost
    if (rd_status) begin
      status_d = status_q & ~avs_readdata[`DRT_IRQ_W-1:0];
    end
    if (ta_ovf) begin
      status_d[`DRT_IRQ_TA] = 1'b1; // see R02 see R16
    end
    if (tb_ovf) begin
      status_d[`DRT_IRQ_TB] = 1'b1; // see R03 see R16
    end
    if (res_event) begin
      status_d[`DRT_IRQ_RES] = 1'b1; // see R15
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      status_q <= `DRT_RST_IRQ;
      mask_q   <= `DRT_RST_IRQ;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      // uses next status and mask so the line follows both at once
      irq_q    <= |(status_d & mask_d);
    end
  end

  // event outputs are registered copies of the pulses
  always @(posedge clock) begin
    if (rst) begin
      ta_overflow_q      <= 1'b0;
      tb_overflow_q      <= 1'b0;
      reserved_trigger_q <= 1'b0;
    end else begin
      ta_overflow_q      <= ta_ovf; // see R02
      tb_overflow_q      <= tb_ovf; // see R03
      reserved_trigger_q <= res_event; // see R15
    end
  end

  // read mux; unmapped indices read zero
  always @* begin
    case (idx)
      `DRT_IDX_CLOCK_CONTROL: rdata_d = clock_control_q;
      `DRT_IDX_TA_RELOAD:     rdata_d = ta_reload_q; // see R01
      `DRT_IDX_TA_COUNT:      rdata_d = ta_count; // see R09
      `DRT_IDX_TB_RELOAD:     rdata_d = tb_reload_q; // see R01
      `DRT_IDX_TB_COUNT:      rdata_d = tb_count; // see R09
      `DRT_IDX_IRQ_MASK:      rdata_d = {5'h00, mask_q};
      `DRT_IDX_IRQ_STATUS:    rdata_d = {5'h00, status_q};
      default:                rdata_d = 8'h00;
    endcase
  end

  // data is captured at the first edge so it stands at the answer edge;
  // a count read therefore shows the value one cycle before acceptance
  always @(posedge clock) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h000000, rdata_d};
    end else if (acc) begin
      avs_readdata <= avs_readdata;
    end
  end

  // limitation: oscillator pins are sampled by clock, so each must
  // toggle slower than half the clock rate to be counted reliably
endmodule

/* File: dv/drt_chk.sv */
`timescale 1ns/10ps
module drt_chk (
  input wire        clock,
  input wire        rst,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire [31:0] avs_readdata,
  input wire        ta_overflow_q,
  input wire        tb_overflow_q,
  input wire        reserved_trigger_q,
  input wire        irq_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire req;
  assign req = avs_read || avs_write;
  bus_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  bus_release_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  bus_idle_a: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  read_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  ta_single_a: assert property (ta_overflow_q |=> !ta_overflow_q [*4])
    else $error("timer a pulse too long");
  tb_single_a: assert property (tb_overflow_q |=> !tb_overflow_q [*4])
    else $error("timer b pulse too long");
  trig_link_a: assert property (reserved_trigger_q |-> tb_overflow_q)
    else $error("trigger without overflow");
  rst_clear_a: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !irq_q && !ta_overflow_q)
    else $error("reset not quiet");
endmodule
bind drt_top drt_chk u_chk (.clock(clock), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .ta_overflow_q(ta_overflow_q), .tb_overflow_q(tb_overflow_q),
  .reserved_trigger_q(reserved_trigger_q), .irq_q(irq_q));

/* File: dv/drt_osc_model.sv */
`timescale 1ns/10ps
// oscillator pin source; stands still while stopped
module drt_osc_model #(
  parameter HALF = 4
) (
  input  wire clock,
  input  wire run,
  output reg  osc
);
  integer n;
  initial begin
    osc = 1'b0;
    n = 0;
  end
  // half period of 4 keeps each level above the 2-cycle sync minimum
  always @(posedge clock) begin
    n <= (n + 1) % HALF;
    if (run && n == HALF - 1) osc <= ~osc;
  end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  reg         clock, rst, rd, wr, wake, res_done, run;
  reg  [3:0]  be;
  reg  [9:0]  addr;
  reg  [31:0] wd;
  wire [31:0] rdata;
  wire        wt, osc1, osc2, trig, ta_ovf, tb_ovf, irq;
  integer     n_errors, checks_done, cyc, n_ta, n_tr, t0, t1, i;
  reg  [7:0]  q;
  reg  [7:0]  idx [0:7];
  drt_osc_model u_o1 (.clock(clock), .run(run), .osc(osc1));
  drt_osc_model u_o2 (.clock(clock), .run(run), .osc(osc2));
  drt_top #(.TA_DIV(2), .TB_DIV(4)) DUT (.clock(clock), .rst(rst),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_byteenable(be),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wt),
    .osc1_pin(osc1), .osc2_pin(osc2), .wake_delay_done(wake),
    .reserved_done(res_done), .reserved_trigger_q(trig),
    .ta_overflow_q(ta_ovf), .tb_overflow_q(tb_ovf), .irq_q(irq));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (ta_ovf === 1'b1) n_ta <= n_ta + 1;
    if (trig === 1'b1) n_tr <= n_tr + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t timeout", $time);
      report_and_stop;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input r, input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      rd <= r;
      wr <= !r;
      addr <= {a, 2'b00};
      wd <= {24'h0, d};
      @(posedge clock);
      while (wt !== 1'b0) @(posedge clock);
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task pulse(input b, output integer t);
    begin
      @(posedge clock);
      while ((b ? tb_ovf : ta_ovf) !== 1'b1) @(posedge clock);
      t = cyc;
    end
  endtask
  task quiet;
    begin
      repeat (8) @(posedge clock);
      t0 = n_ta;
      repeat (300) @(posedge clock);
      chk(8'(n_ta - t0), 8'h0);
    end
  endtask
  task t_reset;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        bus(1, idx[i], 8'h0);
        chk(q, 8'h0);
      end
      $display("t_reset done");
    end
  endtask
  task t_regs;
    begin
      bus(0, 8'heb, 8'hfa);
      bus(0, 8'hed, 8'hfe);
      be <= 4'h0;
      bus(0, 8'heb, 8'h11);
      be <= 4'h1;
      bus(1, 8'heb, 8'h0);
      chk(q, 8'hfa);
      bus(1, 8'hed, 8'h0);
      chk(q, 8'hfe);
      bus(0, 8'hec, 8'h33);
      bus(1, 8'hec, 8'h0);
      chk(q, 8'hfa);
      bus(0, 8'hee, 8'h44);
      bus(1, 8'hee, 8'h0);
      chk(q, 8'hfe);
      $display("t_regs done");
    end
  endtask
  // reload fa: 6 ticks of 2 osc periods of 8 cycles; reload fe on b: 2 x 4 x 8
  task t_timers;
    begin
      bus(0, 8'hfd, 8'h03);
      run <= 1'b1;
      wake <= 1'b1;
      pulse(0, t0);
      pulse(0, t1);
      chk(8'(t1 - t0), 8'd96);
      bus(1, 8'hec, 8'h0);
      chk(q, 8'hfa);
      chk({7'h0, irq}, 8'h1);
      pulse(1, t0);
      pulse(1, t1);
      chk(8'(t1 - t0), 8'd64);
      bus(1, 8'hfe, 8'h0);
      chk(q, 8'h03);
      bus(0, 8'hfd, 8'h00);
      pulse(0, t0);
      repeat (3) @(posedge clock);
      chk({7'h0, irq}, 8'h0);
      bus(0, 8'hfd, 8'h01);
      repeat (2) @(posedge clock);
      chk({7'h0, irq}, 8'h1);
      $display("t_timers done");
    end
  endtask
  task t_gate;
    begin
      wake <= 1'b0;
      quiet;
      wake <= 1'b1;
      bus(0, 8'he8, 8'h80);
      quiet;
      res_done <= 1'b1;
      repeat (4) @(posedge clock);
      res_done <= 1'b0;
      bus(1, 8'he8, 8'h0);
      chk(q, 8'h00);
      $display("t_gate done");
    end
  endtask
  task t_res;
    begin
      chk(8'(n_tr), 8'h0);
      bus(0, 8'he8, 8'h40);
      pulse(1, t0);
      @(posedge clock);
      t1 = n_tr;
      pulse(1, t0);
      repeat (3) @(posedge clock);
      chk(8'(n_tr - t1), 8'h1);
      $display("t_res done");
    end
  endtask
  // reload ff wraps on every tick, so presets keep meeting wraps
  task t_race;
    begin
      bus(0, 8'heb, 8'hff);
      bus(0, 8'hec, 8'h00);
      repeat (4) @(posedge clock);
      t0 = n_ta;
      for (i = 0; i < 32; i = i + 1) bus(0, 8'hec, 8'h00);
      chk(8'(n_ta - t0), 8'd6);
      bus(1, 8'hec, 8'h0);
      chk(q, 8'hff);
      $display("t_race done");
    end
  endtask
  // mid-run reset with the oscillators stopped, so counts stay put
  task t_rerun;
    begin
      run <= 1'b0;
      rst <= 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_reset;
      $display("t_rerun done");
    end
  endtask
  initial begin
    {rd, wr, wake, res_done, run, addr, wd} = 0;
    rst = 1'b1;
    be = 4'h1;
    {n_errors, checks_done, cyc, n_ta, n_tr} = 0;
    idx[0] = 8'he8; idx[1] = 8'heb; idx[2] = 8'hec; idx[3] = 8'hed;
    idx[4] = 8'hee; idx[5] = 8'hfd; idx[6] = 8'hfe; idx[7] = 8'h10;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_timers;
    t_gate;
    t_race;
    t_res;
    t_rerun;
    report_and_stop;
  end
endmodule
